// ==== pre_pkg.sv ====
// Package for the rail enable register slice: offsets, fields, resets, types.
// Assumes one core clock domain and a register port driven by the bus engine.
package pre_pkg;

   // ==========================================================
   // Register offsets and reset values
   localparam logic [7:0] PRE_ADDR_WAKE_FLAGS = 8'h07;
   localparam logic [7:0] PRE_ADDR_UNLOCK_KEY = 8'h10;
   localparam logic [7:0] PRE_ADDR_CONV_EN    = 8'h11;
   localparam logic [7:0] PRE_RESET_VALUE     = 8'h00;
   localparam logic [7:0] PRE_KEY_READBACK    = 8'h00;
   localparam logic [7:0] PRE_CONV_EN_MASK    = 8'h3F;
   localparam logic [7:0] PRE_SEQ_OWN_MASK    = 8'h1F;
   localparam logic [7:0] PRE_SEALED_MASK     = 8'h30;
   localparam logic [7:0] PRE_UNMAPPED_VALUE  = 8'h00;
   localparam int         PRE_NUM_FLAGS       = 8;
   // Unlock value, arbitrary.
   localparam logic [7:0] PRE_UNLOCK_CODE     = 8'h5A;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } pre_req_t;

   typedef struct packed {
      logic       active;
      logic [7:0] onMask;
   } pre_seq_t;

   typedef enum logic [1:0] {
      PRE_ST_OFF,
      PRE_ST_ACTIVE,
      PRE_ST_SUSPEND
   } pre_pwr_t;

endpackage

// ==== pre_unlock.sv ====
// Unlock key tracker: arms a one-shot permit for the next protected write.
// Assumes requests arrive one per cycle from the register port.
module pre_unlock
   import pre_pkg::*;
(
   input  wire logic     ref_clk,
   input  wire logic     rst_n,
   input  wire pre_req_t req,
   output logic          unlocked
);

   logic next_unlocked;

   // ==========================================================
   // Key arming
   // Any protected-register write consumes the permit, valid or not.
   always_comb begin
      next_unlocked = unlocked;
      if (req.wrEn && req.addr == PRE_ADDR_UNLOCK_KEY) begin
         next_unlocked = (req.wrData == PRE_UNLOCK_CODE);
      end else if (req.wrEn && req.addr == PRE_ADDR_CONV_EN) begin
         next_unlocked = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         unlocked <= 1'b0;
      end else begin
         unlocked <= next_unlocked;
      end
   end

endmodule

// ==== pre_wake_flags.sv ====
// Wake-up flag bank: records which outputs stayed on across a suspend.
// Assumes the power state and keep levels come from the device core.
module pre_wake_flags
   import pre_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic       wakeFromSuspend,
   input  wire logic       powerUpFromOff,
   input  wire logic [7:0] keptInSuspend,
   output logic [7:0]      flags
);

   logic [7:0] next_flags;

   // ==========================================================
   // Per-bit flag update; each bit is independent.
   genvar i;
   generate
      for (i = 0; i < PRE_NUM_FLAGS; i++) begin : gFlag
         always_comb begin
            next_flags[i] = flags[i];
            if (powerUpFromOff) begin
               next_flags[i] = 1'b0;
            end else if (wakeFromSuspend) begin
               next_flags[i] = keptInSuspend[i];
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= PRE_RESET_VALUE;
      end else begin
         flags <= next_flags;
      end
   end

endmodule

// ==== pre_rail_regs.sv ====
// Rail enable register slice: wake flags, unlock key and converter enables.
// Assumes the serial bus engine presents one request per cycle, same clock.
// Function
// - Flag set when output kept during suspend.
// - Flag cleared on off-start or disabled output.
// - Flag register at 0x07, read-only, reset zero.
// - Key register at 0x10 takes unlock writes.
// - Key register always reads zero.
// - Enable register 0x11 protected, resets zero.
// - Bits 0..5 switch converters one..six.
// - Converters five, six disable only if sealed.
// - Sequencer writes converter one..five enables.
// - Bits 7..6 reserved, read zero.
// - Seal status 0 native, 1 broken.
module pre_rail_regs
   import pre_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire pre_req_t   req,
   output logic [7:0]      rdData,
   input  wire logic       factorySealState,
   input  wire pre_seq_t   seq,
   input  wire logic       wakeFromSuspend,
   input  wire logic       powerUpFromOff,
   input  wire logic [7:0] keptInSuspend,
   output logic [5:0]      convOn
);

   logic       unlocked;
   logic [7:0] wakeFlags;
   logic [7:0] convEn;
   logic [7:0] next_convEn;
   logic [7:0] next_rdData;
   logic [7:0] wrVal;

   // ==========================================================
   // Submodules
   pre_unlock uUnlock (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .req      (req),
      .unlocked (unlocked)
   );

   pre_wake_flags uFlags (
      .ref_clk         (ref_clk),
      .rst_n           (rst_n),
      .wakeFromSuspend (wakeFromSuspend),
      .powerUpFromOff  (powerUpFromOff),
      .keptInSuspend   (keptInSuspend),
      .flags           (wakeFlags)
   );

   // ==========================================================
   // Converter enable register.
   // The sequencer has priority over the host because rail state is truth.
   always_comb begin
      next_convEn = convEn;
      wrVal       = req.wrData & PRE_CONV_EN_MASK;
      if (req.wrEn && req.addr == PRE_ADDR_CONV_EN && unlocked) begin
         next_convEn = wrVal;
      end
      if (seq.active) begin
         next_convEn = (next_convEn & ~PRE_SEQ_OWN_MASK)
                     | (seq.onMask & PRE_SEQ_OWN_MASK);
      end
      // A part with a broken seal cannot turn off the backup converters. The hold is
      // applied last, so the sequencer cannot drop converter five either.
      if (factorySealState) begin
         next_convEn = next_convEn | (convEn & PRE_SEALED_MASK);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         convEn <= PRE_RESET_VALUE;
      end else begin
         convEn <= next_convEn;
      end
   end

   assign convOn = convEn[5:0];

   // ==========================================================
   // Read path, registered; data appears the cycle after rdEn.
   always_comb begin
      next_rdData = rdData;
      if (req.rdEn) begin
         if (req.addr == PRE_ADDR_WAKE_FLAGS) begin
            next_rdData = wakeFlags;
         end else if (req.addr == PRE_ADDR_UNLOCK_KEY) begin
            next_rdData = PRE_KEY_READBACK;
         end else if (req.addr == PRE_ADDR_CONV_EN) begin
            next_rdData = convEn & PRE_CONV_EN_MASK;
         end else begin
            next_rdData = PRE_UNMAPPED_VALUE;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData <= PRE_RESET_VALUE;
      end else begin
         rdData <= next_rdData;
      end
   end

   // ==========================================================
   // Checks
   property p_key_reads_zero;
      @(posedge ref_clk) disable iff (!rst_n)
      (req.rdEn && req.addr == PRE_ADDR_UNLOCK_KEY) |=> rdData == 8'h00;
   endproperty
   a_key_reads_zero: assert property (p_key_reads_zero)
      else $error("Key register read not zero.");

   property p_reserved_zero;
      @(posedge ref_clk) disable iff (!rst_n)
      convEn[7:6] == 2'b00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("Reserved enable bits set.");

   property p_locked_ignored;
      @(posedge ref_clk) disable iff (!rst_n)
      (req.wrEn && req.addr == PRE_ADDR_CONV_EN && !unlocked && !seq.active)
      |=> $stable(convEn);
   endproperty
   a_locked_ignored: assert property (p_locked_ignored)
      else $error("Locked write changed enables.");

   property p_unlocked_write;
      @(posedge ref_clk) disable iff (!rst_n)
      (req.wrEn && req.addr == PRE_ADDR_CONV_EN && unlocked && !seq.active
       && !factorySealState)
      |=> convEn == ($past(req.wrData) & 8'h3F);
   endproperty
   a_unlocked_write: assert property (p_unlocked_write)
      else $error("Unlocked write not stored.");

   property p_sealed_keep;
      @(posedge ref_clk) disable iff (!rst_n)
      (factorySealState && convEn[5]) |=> convEn[5];
   endproperty
   a_sealed_keep: assert property (p_sealed_keep)
      else $error("Sealed converter six turned off.");

   property p_seq_owns;
      @(posedge ref_clk) disable iff (!rst_n)
      seq.active |=> convEn[4:0] == ($past(seq.onMask[4:0])
         | ($past(factorySealState)
            ? ($past(convEn[4:0]) & PRE_SEALED_MASK[4:0]) : 5'h00));
   endproperty
   a_seq_owns: assert property (p_seq_owns)
      else $error("Sequencer value not applied.");

   property p_flag_set;
      @(posedge ref_clk) disable iff (!rst_n)
      (wakeFromSuspend && !powerUpFromOff) |=> ##1
      (rdData == $past(keptInSuspend, 2)) || !$past(req.rdEn)
      || $past(req.addr) != PRE_ADDR_WAKE_FLAGS;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("Wake flags not reported.");

   property p_flag_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      powerUpFromOff |=> wakeFlags == 8'h00;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("Flags not cleared after off start.");

   property p_flag_read;
      @(posedge ref_clk) disable iff (!rst_n)
      (req.rdEn && req.addr == PRE_ADDR_WAKE_FLAGS)
      |=> rdData == $past(wakeFlags);
   endproperty
   a_flag_read: assert property (p_flag_read)
      else $error("Flag read mismatch.");

   property p_unlock_arms;
      @(posedge ref_clk) disable iff (!rst_n)
      (req.wrEn && req.addr == PRE_ADDR_UNLOCK_KEY
       && req.wrData == PRE_UNLOCK_CODE) |=> unlocked;
   endproperty
   a_unlock_arms: assert property (p_unlock_arms)
      else $error("Key write did not unlock.");

   // Once the seal is broken converter five must stay on as well.
   property p_sealed_keep_five;
      @(posedge ref_clk) disable iff (!rst_n)
      (factorySealState && convEn[4]) |=> convEn[4];
   endproperty
   a_sealed_keep_five: assert property (p_sealed_keep_five)
      else $error("Sealed converter five turned off.");

   // A wrong key must not leave a permit behind.
   property p_wrong_key;
      @(posedge ref_clk) disable iff (!rst_n)
      (req.wrEn && req.addr == PRE_ADDR_UNLOCK_KEY
       && req.wrData != PRE_UNLOCK_CODE) |=> !unlocked;
   endproperty
   a_wrong_key: assert property (p_wrong_key)
      else $error("Wrong key left the permit armed.");

   // Each protected write uses up the permit, taken or not.
   property p_write_consumes;
      @(posedge ref_clk) disable iff (!rst_n)
      (req.wrEn && req.addr == PRE_ADDR_CONV_EN) |=> !unlocked;
   endproperty
   a_write_consumes: assert property (p_write_consumes)
      else $error("Permit survived a protected write.");

   // Enable readback shows the stored bits with the reserved pair at zero.
   property p_conv_read;
      @(posedge ref_clk) disable iff (!rst_n)
      (req.rdEn && req.addr == PRE_ADDR_CONV_EN)
      |=> rdData == ($past(convEn) & PRE_CONV_EN_MASK);
   endproperty
   a_conv_read: assert property (p_conv_read)
      else $error("Enable readback mismatch.");

   // Read data stands until the next read.
   property p_rd_holds;
      @(posedge ref_clk) disable iff (!rst_n)
      !req.rdEn |=> $stable(rdData);
   endproperty
   a_rd_holds: assert property (p_rd_holds)
      else $error("Read data changed without a read.");

   // Flags only move on a power event.
   property p_flags_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      (!wakeFromSuspend && !powerUpFromOff) |=> $stable(wakeFlags);
   endproperty
   a_flags_hold: assert property (p_flags_hold)
      else $error("Wake flags changed without an event.");

   // Without a protected write or the sequencer the enables stay put.
   property p_conv_idle;
      @(posedge ref_clk) disable iff (!rst_n)
      (!seq.active && !(req.wrEn && req.addr == PRE_ADDR_CONV_EN))
      |=> $stable(convEn);
   endproperty
   a_conv_idle: assert property (p_conv_idle)
      else $error("Enables changed while idle.");

   // The converter outputs follow the enable register bit for bit.
   property p_conv_out;
      @(posedge ref_clk) disable iff (!rst_n)
      (req.wrEn && req.addr == PRE_ADDR_CONV_EN && unlocked && !seq.active
       && !factorySealState) |=> convOn == $past(req.wrData[5:0]);
   endproperty
   a_conv_out: assert property (p_conv_out)
      else $error("Converter outputs do not follow the write.");

endmodule

// ==== pre_host_model.sv ====
// Host model: single-byte reads and writes on the register port.
// Assumes the bench clock; requests change on the falling edge.
module pre_host_model
   import pre_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic [7:0] rdData,
   output pre_req_t        req
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Bus tasks
   // Released address and data show the inverse, never the last value.
   initial req = '0;

   // A write holds for exactly one taking edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      req <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
      @(negedge ref_clk);
      req <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: ~d};
   endtask

   // Read data is taken at the falling edge, half a cycle after the taking edge.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      req <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
      @(negedge ref_clk);
      d = rdData;
      req <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: 8'hFF};
   endtask
endmodule

// ==== tb_top.sv ====
// Bench for the rail enable slice, compared with a behavioural model.
// Assumes pre_pkg and the host model are compiled first.
module tb_top;
   import pre_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic       refClk = 0;
   logic       rstN = 0;
   logic       seal = 0;
   logic       wake = 0;
   logic       pwrUp = 0;
   logic [7:0] kept = 0;
   pre_seq_t   seq = '0;
   pre_req_t   req;
   logic [7:0] rdData;
   logic [5:0] convOn;
   logic [7:0] rd;
   logic [7:0] nv;
   logic [7:0] expEn = 0;
   logic [7:0] expFlags = 0;
   logic [31:0] r;
   bit         armed = 0;
   int         n_mismatch = 0;
   int         checked = 0;
   int         seed = 32'h5e124946;

   // ==========================================================
   // Clock, instances and checks
   always #2 refClk = ~refClk;

   pre_host_model u_pre_host_model (.ref_clk(refClk), .rdData(rdData),
      .req(req));

   pre_rail_regs u_pre_rail_regs (.ref_clk(refClk), .rst_n(rstN),
      .req(req), .rdData(rdData), .factorySealState(seal), .seq(seq),
      .wakeFromSuspend(wake), .powerUpFromOff(pwrUp),
      .keptInSuspend(kept), .convOn(convOn));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      u_pre_host_model.rd(a, rd);
      chk(rd, exp);
   endtask

   task automatic end_sim;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Watchdog sized well above the roughly 1800 cycles the tests need.
   initial begin
      repeat (20000) @(posedge refClk);
      n_mismatch++;
      end_sim();
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(negedge refClk);
      rstN = 1;
      rdchk(PRE_ADDR_WAKE_FLAGS, 8'h00);
      rdchk(PRE_ADDR_CONV_EN, 8'h00);
      $display("reset test done");
      for (int i = 0; i < 300; i++) begin
         r = $random(seed);
         case (r[2:0])
            3'd0, 3'd1: begin
               kept = r[15:8];
               wake = ~r[0];
               pwrUp = r[0];
               @(negedge refClk);
               wake = 0;
               pwrUp = 0;
               expFlags = r[0] ? 8'h00 : kept;
            end
            3'd2, 3'd3: begin
               // Without a fresh key the write counts only if still armed.
               if (r[0])
                  u_pre_host_model.wr(PRE_ADDR_UNLOCK_KEY, PRE_UNLOCK_CODE);
               armed = armed | r[0];
               u_pre_host_model.wr(PRE_ADDR_CONV_EN, r[15:8]);
               nv = r[15:8] & PRE_CONV_EN_MASK;
               if (seal)
                  nv[5:4] = nv[5:4] | expEn[5:4];
               if (armed)
                  expEn = nv;
               armed = 0;
            end
            3'd4: begin
               // The raw mask goes out, so a sealed clear is really tried.
               seq = '{active: 1'b1, onMask: r[15:8]};
               @(negedge refClk);
               seq = '0;
               nv = r[15:8];
               if (seal)
                  nv[4] = nv[4] | expEn[4];
               expEn[4:0] = nv[4:0];
            end
            3'd5: begin
               // Half the keys are random, so a wrong key must disarm.
               nv = r[16] ? PRE_UNLOCK_CODE : r[15:8];
               u_pre_host_model.wr(PRE_ADDR_UNLOCK_KEY, nv);
               armed = (nv == PRE_UNLOCK_CODE);
               rdchk(PRE_ADDR_UNLOCK_KEY, 8'h00);
               rdchk({3'b001, r[12:8]}, 8'h00);
            end
            default: seal = r[8];
         endcase
         chk({2'b00, convOn}, expEn);
         rdchk(PRE_ADDR_CONV_EN, expEn);
         rdchk(PRE_ADDR_WAKE_FLAGS, expFlags);
      end
      $display("random test done");
      // A second reset in mid-run must bring every register back to zero.
      rstN = 0;
      repeat (2) @(negedge refClk);
      rstN = 1;
      expEn = 0;
      expFlags = 0;
      armed = 0;
      chk({2'b00, convOn}, 8'h00);
      rdchk(PRE_ADDR_WAKE_FLAGS, 8'h00);
      rdchk(PRE_ADDR_CONV_EN, 8'h00);
      $display("mid-run reset test done");
      end_sim();
   end
endmodule
